//--- isg_chk.sv
// port checks for the gating block
`timescale 1ns/1ns
module isg_chk (input wire clk, rst, swen_wr_stb, output_enable,
    logic_supply_ok, switch_supply_ok, shutdown_fault, current_fault_state,
    fault_indicator_n, fault_indicator_oe, input wire [3:0] swen_wr_data,
    channel_switch_enable_bits, channel_switch_output, overtemp_constraint,
    channel_status_indicator_oe);
default clocking @(posedge clk); endclocking
default disable iff (rst);
// aliases keep each property short; outputs lag their cause by one edge
wire ok = logic_supply_ok & switch_supply_ok & ~shutdown_fault;
wire [3:0] q = channel_switch_output, s = channel_status_indicator_oe;
property p_ld; !logic_supply_ok |=> !q && !fault_indicator_oe; endproperty
a_ld: assert property (p_ld) else $error("ld");
property p_sd; !switch_supply_ok |=> current_fault_state; endproperty
a_sd: assert property (p_sd) else $error("sd");
property p_ft; !ok |=> !q && !s; endproperty
a_ft: assert property (p_ft) else $error("ft");
property p_cl; ok |=> !current_fault_state; endproperty
a_cl: assert property (p_cl) else $error("cl");
property p_on; ok && output_enable && !overtemp_constraint |=>
    q == $past(channel_switch_enable_bits); endproperty
a_on: assert property (p_on) else $error("on");
property p_oe; !output_enable |=> !q; endproperty
a_oe: assert property (p_oe) else $error("oe");
property p_wr; swen_wr_stb |=>
    channel_switch_enable_bits == $past(swen_wr_data); endproperty
a_wr: assert property (p_wr) else $error("wr");
property p_pn; s == q && fault_indicator_oe != fault_indicator_n; endproperty
a_pn: assert property (p_pn) else $error("pn");
cover property (q[0]);
cover property (current_fault_state);
cover property (overtemp_constraint[1] && q[0]);
endmodule
bind isg_gating isg_chk chk (.*);

//--- isg_gating.v
// output gating and fault indication for a four channel isolated switch
`timescale 1ns/1ns
`include "isg_gating_map.vh"

module isg_gating #(
    parameter SERIAL_VARIANT = 1,
    parameter NUM_CH         = `ISG_NUM_CH
) (
    input  wire              clk,
    input  wire              rst,
    input  wire              swen_wr_stb,
    input  wire [NUM_CH-1:0] swen_wr_data,
    input  wire              flt_cfg_wr_stb,
    input  wire [`ISG_CFG_W-1:0] flt_cfg_wr_data,
    input  wire [NUM_CH-1:0] channel_enable_pin,
    input  wire              output_enable,
    input  wire              logic_supply_ok,
    input  wire              switch_supply_ok,
    input  wire              shutdown_fault,
    input  wire [NUM_CH-1:0] overtemp_constraint,
    input  wire              overvolt_constraint,
    output reg  [NUM_CH-1:0] channel_switch_enable_bits,
    output reg  [NUM_CH-1:0] channel_switch_output,
    output reg  [NUM_CH-1:0] channel_status_indicator_n,
    output reg  [NUM_CH-1:0] channel_status_indicator_oe,
    output reg               fault_indicator_n,
    output reg               fault_indicator_oe,
    output reg               current_fault_state
);

    // the gating is a straight function of the present inputs and of
    // each channel's own registered output
    // the only storage is the host-written enable word, the indicator
    // configuration and the pin flip-flops themselves
    // a shutdown fault holds every channel off, while a constraint fault
    // only lights the indicator, except that a hot channel which is off
    // may not turn on
    // nothing here latches a fault, so recovery needs no host write
    // limitation: supply and fault flags are taken as already clean and
    // synchronous; any filtering belongs upstream of this block
    // trade-off: every pin lags its cause by one clock so that each
    // output leaves a flip-flop and never glitches on a decode race

    // indicator configuration fields, named once for readability
    localparam MASK_BIT = `ISG_CFG_MASK_CONSTR;
    localparam OFF_BIT  = `ISG_CFG_IND_DISABLE;

    // pin levels held through reset: outputs off, open drains released
    localparam [NUM_CH-1:0] CH_OFF  = {NUM_CH{1'b0}};
    localparam [NUM_CH-1:0] LED_REL = {NUM_CH{1'b1}};

    // host-written configuration, one bit per fault indicator option
    reg  [`ISG_CFG_W-1:0] flt_cfg_ff;
    // shared fault terms: nxt_fault feeds every channel, constr_any only the indicator
    reg                   nxt_fault;
    reg                   constr_any;
    // enables after the variant select, one bit per channel
    wire [NUM_CH-1:0]     ch_en;
    // next channel outputs and status indicator drives
    wire [NUM_CH-1:0]     nxt_out;
    wire [NUM_CH-1:0]     nxt_led_oe;
    // fault indicator request and its supply-qualified drive
    wire                  nxt_flt_req;
    wire                  nxt_flt_oe;

    // per-channel decisions
    // each channel sees the same shared terms plus its own flags

    // one channel's next on state; one function for all channels keeps
    // them from drifting apart when the gating is changed later
    function chan_gate;
        input powered;  // logic supply above threshold
        input fault;    // shutdown class fault present
        input ot;       // over-temperature constraint on this channel
        input was_on;   // this channel's registered output
        input en;       // selected channel enable
        input oe;       // global output enable
        begin
            if (!powered) begin
                // logic side down: every channel off
                chan_gate = 1'b0;
            end else if (fault) begin
                // detected fault holds the channel off
                chan_gate = 1'b0;
            end else if (ot && !was_on) begin
                // hot and still off: the turn-on is refused
                chan_gate = 1'b0;
            end else if (!en || !oe) begin
                // either enable low keeps the channel off
                chan_gate = 1'b0;
            end else begin
                // both enables high; an output already on rides out heat
                chan_gate = 1'b1;
            end
        end
    endfunction

    // fault indicator request before the supply qualifier; real faults
    // always show unless the host turned the indicator off entirely
    function flt_request;
        input [`ISG_CFG_W-1:0] cfg;     // host configuration word
        input                  fault;   // shutdown class fault
        input                  constr;  // any constraint fault
        begin
            if (cfg[OFF_BIT]) begin
                flt_request = 1'b0;
            end else if (fault) begin
                flt_request = 1'b1;
            end else if (cfg[MASK_BIT]) begin
                // constraint faults hidden from the pin by the host
                flt_request = 1'b0;
            end else begin
                flt_request = constr;
            end
        end
    endfunction

    // per-variant selection
    // fixed at build time, so the unused branch costs no logic

    // enable source per variant: register bits or direct pins
    function [NUM_CH-1:0] pick_enables;
        input [NUM_CH-1:0] reg_bits;  // host-written enable word
        input [NUM_CH-1:0] pin_bits;  // direct enable pins
        begin
            if (SERIAL_VARIANT != 0) begin
                pick_enables = reg_bits;
            end else begin
                pick_enables = pin_bits;
            end
        end
    endfunction

    // status indicator drive; the pin-enabled variant has none
    function led_drive;
        input on;  // channel's next on state
        begin
            if (SERIAL_VARIANT != 0) begin
                led_drive = on;
            end else begin
                led_drive = 1'b0;
            end
        end
    endfunction

    // host-written registers
    // a strobe during reset is dropped, reset wins

    // channel enable bits, written whole by the host
    always @(posedge clk) begin
        if (rst) begin
            channel_switch_enable_bits <= `ISG_SWEN_RST;
        end else if (swen_wr_stb) begin
            channel_switch_enable_bits <= swen_wr_data;
        end
    end

    // fault indicator configuration, written whole by the host
    always @(posedge clk) begin
        if (rst) begin
            flt_cfg_ff <= `ISG_CFG_RST;
        end else if (flt_cfg_wr_stb) begin
            flt_cfg_ff <= flt_cfg_wr_data;
        end
    end

    // shared fault decode
    // worked out once here rather than per channel

    // fault has no memory of its own, so it clears as causes vanish
    always @* begin
        nxt_fault = 1'b0;
        if (!switch_supply_ok) begin
            nxt_fault = 1'b1;
        end
        if (shutdown_fault) begin
            nxt_fault = 1'b1;
        end
        // the combined constraint term reaches only the indicator; overtemp still blocks a turn-on per channel
        constr_any = 1'b0;
        if (overvolt_constraint) begin
            constr_any = 1'b1;
        end
        if (|overtemp_constraint) begin
            constr_any = 1'b1;
        end
    end

    // select enables; inputs are taken as driven, never floating
    assign ch_en = pick_enables(channel_switch_enable_bits,
                                channel_enable_pin);

    // indicator released while the logic side is unpowered
    assign nxt_flt_req = flt_request(flt_cfg_ff, nxt_fault, constr_any);
    assign nxt_flt_oe  = logic_supply_ok & nxt_flt_req;

    // per-channel gating
    // channel g is fed by enable bit g, index zero first

    genvar g;
    generate
        for (g = 0; g < NUM_CH; g = g + 1) begin : g_ch
            // this channel's own view of its inputs
            wire hot    = overtemp_constraint[g];
            wire was_on = channel_switch_output[g];
            wire en     = ch_en[g];
            assign nxt_out[g] = chan_gate(logic_supply_ok,
                                          nxt_fault,
                                          hot,
                                          was_on,
                                          en,
                                          output_enable);
            // status pin follows the channel it belongs to
            assign nxt_led_oe[g] = led_drive(nxt_out[g]);
        end
    endgenerate

    // registered pins
    // one process per pin keeps each reset value next to its pin

    // channel outputs: one clock of latency traded for clean pins
    // no further stage is added anywhere on the path
    always @(posedge clk) begin
        if (rst) begin
            channel_switch_output <= CH_OFF;
        end else begin
            channel_switch_output <= nxt_out;
        end
    end

    // status indicator enables pull low while a channel is on
    // released pins read high through the board pull-ups
    always @(posedge clk) begin
        if (rst) begin
            channel_status_indicator_oe <= CH_OFF;
        end else begin
            channel_status_indicator_oe <= nxt_led_oe;
        end
    end

    // status indicator levels mirror the enables, active low
    // driven from the same term so level and enable never disagree
    always @(posedge clk) begin
        if (rst) begin
            channel_status_indicator_n <= LED_REL;
        end else begin
            channel_status_indicator_n <= ~nxt_led_oe;
        end
    end

    // fault state as seen by the host, detected while any cause stands
    // it drops in the clock after the last cause goes away
    always @(posedge clk) begin
        if (rst) begin
            current_fault_state <= 1'b0;
        end else begin
            current_fault_state <= nxt_fault;
        end
    end

    // fault indicator enable, open drain pulling low
    // released whenever the logic side is unpowered
    always @(posedge clk) begin
        if (rst) begin
            fault_indicator_oe <= 1'b0;
        end else begin
            fault_indicator_oe <= nxt_flt_oe;
        end
    end

    // fault indicator level, active low
    // high while released so the pin never fights its pull-up
    always @(posedge clk) begin
        if (rst) begin
            fault_indicator_n <= 1'b1;
        end else begin
            fault_indicator_n <= ~nxt_flt_oe;
        end
    end

endmodule

//--- isg_gating_map.vh
// constants for the isolated switch output gating block
`ifndef ISG_GATING_MAP_VH
`define ISG_GATING_MAP_VH
// number of switch channels
`define ISG_NUM_CH           4
// fault indicator configuration field positions
`define ISG_CFG_MASK_CONSTR  0
`define ISG_CFG_IND_DISABLE  1
`define ISG_CFG_W            2
// reset values
`define ISG_CFG_RST          2'h0
`define ISG_SWEN_RST         4'h0
`endif

//--- isg_gating_test.sv
// self-checking bench for the gating block
`timescale 1ns/1ns
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin fails++; \
    $display("unexpected %0t %h %h", $time, a, b); end end
module isg_gating_test;
reg clk = 1'h0, rst = 1'h1;
int fails = 0, num_checks = 0;
wire [20:0] i;
wire [5:0] st; // fault state, fault indicator, outputs
wire [3:0] led;
always #5 clk = ~clk;
isg_host host (.clk(clk), .i(i));
isg_gating dut (.clk(clk), .rst(rst), .output_enable(i[4]),
    .logic_supply_ok(i[3]), .switch_supply_ok(i[2]), .shutdown_fault(i[1]),
    .overvolt_constraint(i[0]), .overtemp_constraint(i[8:5]),
    .channel_enable_pin(i[12:9]), .flt_cfg_wr_stb(i[13]), .swen_wr_stb(i[14]),
    .swen_wr_data(i[18:15]), .flt_cfg_wr_data(i[20:19]),
    .channel_switch_enable_bits(), .channel_switch_output(st[3:0]),
    .channel_status_indicator_n(led), .channel_status_indicator_oe(),
    .fault_indicator_n(st[4]), .fault_indicator_oe(),
    .current_fault_state(st[5]));
task end_of_test;
    if (fails == 0 && num_checks > 0)
        $display("Regression OK");
    else
        $display("Regression broken");
    $finish;
endtask
// apply levels and compare the output summary
task t(input [3:0] o, input [4:0] v, input [5:0] x);
    host.set(o, v);
    `CHK(st, x)
endtask
// supply, fault and constraint rows, then fault indicator config
initial begin
    repeat (8) @(posedge clk) #1;
    rst = 1'h0;
    t(0, 5'h1c, 6'h10);
    host.wr(0, 4'h5);
    t(0, 5'h1c, 6'h15);
    `CHK(led, 4'ha)
    host.pin(4'ha);
    t(0, 5'h1c, 6'h15);
    t(0, 5'h0c, 6'h10);
    t(0, 5'h1e, 6'h20);
    t(0, 5'h1c, 6'h15);
    t(0, 5'h18, 6'h20);
    t(0, 5'h14, 6'h10);
    `CHK(led, 4'hf)
    t(0, 5'h1c, 6'h15);
    t(3, 5'h1c, 6'h05);
    host.wr(0, 4'hf);
    t(3, 5'h1d, 6'h0d);
    `CHK(led, 4'h2)
    host.wr(1, 4'h1);
    t(3, 5'h1c, 6'h1d);
    host.wr(1, 4'h2);
    t(0, 5'h1e, 6'h30);
    end_of_test;
end
endmodule

//--- isg_host.sv
// host model driving every gating input except clock and reset
`timescale 1ns/1ns
module isg_host (input wire clk, output reg [20:0] i);
// defined levels from time zero, direct pins unused here
initial i = 21'h0;
// one strobed write, c picks the fault config over the enables
task wr(input c, input [3:0] d);
    @(posedge clk) #1 i[20:13] = {d[1:0], d, !c, c};
    @(posedge clk) #1 i[14:13] = 2'h0;
endtask
// direct enable pins, only the pin-enabled variant listens to them
task pin(input [3:0] p);
    @(posedge clk) #1 i[12:9] = p;
endtask
// new levels, then room for the registered outputs to follow
task set(input [3:0] t, input [4:0] v);
    @(posedge clk) #1 i[8:0] = {t, v};
    repeat (3) @(posedge clk) #1;
endtask
endmodule
